// ### src/ucfrb_pkg.sv
package ucfrb_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_CTRLB = 8'h08;
  localparam logic [7:0] ADDR_CTRLC = 8'h0c;
  localparam logic [7:0] ADDR_BAUDL = 8'h10;
  localparam logic [7:0] ADDR_BAUDH = 8'h14;
  localparam logic [7:0] ADDR_CLKDIR = 8'h18;
  // control_status_a fields
  localparam int ST_RXC = 7;
  localparam int ST_TXC = 6;
  localparam int ST_UDRE = 5;
  localparam int ST_FE = 4;
  localparam int ST_DOR = 3;
  localparam int ST_PERR = 2;
  localparam int ST_U2X = 1;
  // control_status_b fields
  localparam int CB_RXEN = 4;
  localparam int CB_TXEN = 3;
  localparam int CB_CSZ2 = 2;
  localparam int CB_RX_NINTH_BIT = 1;
  localparam int CB_TX_NINTH_BIT = 0;
  // control_status_c fields
  localparam int CC_SYNC = 6;
  localparam int CC_PARH = 5;
  localparam int CC_PARL = 4;
  localparam int CC_STOP = 3;
  localparam int CC_CSZH = 2;
  localparam int CC_CSZL = 1;
  localparam int CC_POL = 0;
  localparam int CD_DIR = 0;
  // Reset values
  localparam logic [1:0] RST_CSZ = 2'h3;
  localparam logic [11:0] RST_DIVISOR = 12'h000;
  // Sampling states per bit, minus one
  localparam logic [3:0] NORM_DIV_M1 = 4'hf;
  localparam logic [3:0] DBL_DIV_M1 = 4'h7;
  localparam logic [3:0] NORM_HALF_M1 = 4'h7;
  localparam logic [3:0] DBL_HALF_M1 = 4'h3;
  localparam logic [2:0] CSZ_NINE = 3'h7;
  localparam logic [3:0] CSZ_BASE = 4'h5;
  localparam logic [3:0] NINE_BITS = 4'h9;
  localparam logic [1:0] RXQ_FULL = 2'h2;
  typedef struct packed {
    logic perr;
    logic overrun_flag;
    logic fe;
    logic [8:0] data;
  } ucfrb_rx_entry_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_START = 3'b010,
    RX_BITS = 3'b100
  } ucfrb_rx_state_t;
endpackage

// ### src/ucfrb_rxq_if.sv
`timescale 1ns/1ps
interface ucfrb_rxq_if;
  logic push;
  ucfrb_pkg::ucfrb_rx_entry_t push_entry;
  logic pop;
  logic [1:0] count;
  ucfrb_pkg::ucfrb_rx_entry_t head;
  modport owner(output push, output push_entry, output pop, input count, input head);
  modport queue(input push, input push_entry, input pop, output count, output head);
endinterface

// ### src/ucfrb_rx_fifo.sv
`timescale 1ns/1ps
module ucfrb_rx_fifo (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Queue port
  ucfrb_rxq_if.queue q
);
  ucfrb_pkg::ucfrb_rx_entry_t slot [2];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic do_push;
  logic do_pop;

  assign do_pop = q.pop && (count != 2'h0);
  assign do_push = q.push && ((count != ucfrb_pkg::RXQ_FULL) || do_pop);
  assign q.count = count;
  assign q.head = slot[rd_ptr];

  // Flags and ninth bit ride in the same slot as their character
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      slot[0] <= '0;
      slot[1] <= '0;
      wr_ptr <= 1'b0;
    end else if (do_push) begin
      slot[wr_ptr] <= q.push_entry;
      wr_ptr <= ~wr_ptr;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (do_pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, do_push} - {1'b0, do_pop};
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_queue_depth_bound: assert property (count <= ucfrb_pkg::RXQ_FULL)
    else $error("receive queue holds more than two entries");
  a_queue_first_out: assert property (q.push && !q.pop && count == 2'h0 |=> q.head == $past(q.push_entry))
    else $error("first pushed entry is not at the head");
  a_queue_pop_one: assert property (q.pop && !q.push && count == 2'h2 |=> count == 2'h1)
    else $error("read did not consume exactly one entry");
endmodule

// ### src/ucfrb_top.sv
`timescale 1ns/1ps
// What this block does
// - Two receive buffer entries form a circular queue; each data read consumes one.
// - Frame error, overrun and ninth bit are stored with each character.
// - With both entries full, the new character waits in the shifter until next start.
// - Sync mode bit picks async or sync; pin direction picks master or slave.
// - Serial clock pin is driven only in synchronous master operation.
// - Baud counter reloads divisor at zero or low-byte write; ticks once per zero.
// - Bit rate is tick rate over 16, 8 or 2 by mode.
// - Receiver recovery uses 16, 8 or 2 states per bit by mode bits.
// - Divisor is twelve bits from high and low registers.
// - Double speed affects only async; software keeps it clear in sync.
// - Double speed receiver takes 8 samples per bit instead of 16.
// - Slave clock passes a sync register and edge detector, two clocks delay.
// - Sync data is sampled on the edge opposite to the change edge.
// - Polarity clear: change rising, sample falling; set: the reverse.
// - Frame: low start, 5 to 9 data, optional parity, one or two high stops.
// - Start, data LSB first, parity, stops; frames may follow back to back.
// - Transmitter and receiver share one frame format setting.
// - Receiver checks only first stop bit; zero there flags a frame error.
// - Parity is XOR of data bits, inverted for odd parity.
// - Parity bit is inserted only when the upper parity bit is one.
// - Size code seven gives nine bits; ninth transmit bit from control bit.
module ucfrb_top (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic RSTN_IN,
  // APB slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // Serial data
  input wire logic RXD_IN,
  output logic TXD_OUT,
  // Serial clock pin
  input wire logic XCK_IN,
  output logic XCK_OUT,
  output logic XCK_OE_OUT
);
  function automatic logic mapped(input logic [7:0] a);
    return a == ucfrb_pkg::ADDR_DATA || a == ucfrb_pkg::ADDR_STAT || a == ucfrb_pkg::ADDR_CTRLB ||
           a == ucfrb_pkg::ADDR_CTRLC || a == ucfrb_pkg::ADDR_BAUDL || a == ucfrb_pkg::ADDR_BAUDH ||
           a == ucfrb_pkg::ADDR_CLKDIR;
  endfunction

  function automatic logic [3:0] char_bits(input logic [2:0] code);
    // Codes four to six are reserved and fall back to their low two bits
    if (code == ucfrb_pkg::CSZ_NINE) begin
      return ucfrb_pkg::NINE_BITS;
    end
    return {2'b00, code[1:0]} + ucfrb_pkg::CSZ_BASE;
  endfunction

  function automatic logic parity_of(input logic [8:0] d, input logic [3:0] n, input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(n)) begin
        p = p ^ d[i];
      end
    end
    return p;
  endfunction

  function automatic logic [12:0] make_frame(input logic [8:0] d, input logic [3:0] n, input logic pe,
                                             input logic pbit);
    logic [12:0] f;
    f = 13'h1fff;
    f[0] = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(n)) begin
        f[i + 1] = d[i];
      end
    end
    if (pe) begin
      f[n + 4'h1] = pbit;
    end
    return f;
  endfunction

  // Software-visible state
  logic double_speed_bit;
  logic transmit_complete_flag;
  logic rxen;
  logic txen;
  logic char_size_top_bit;
  logic tx_ninth_bit;
  logic sync_mode_select;
  logic [1:0] parity_mode_field;
  logic stop_bits_select;
  logic [1:0] char_size_low;
  logic sync_clock_polarity;
  logic clock_pin_direction;
  logic [11:0] baud_divisor;
  logic [8:0] tx_buf;
  logic tx_full;
  logic [31:0] next_rdata;

  logic acc_done;
  logic wr_en;
  logic rd_en;
  logic [3:0] nbits;
  logic par_en;
  logic [3:0] div_m1;
  logic [3:0] half_m1;
  logic sync_master;
  logic sync_slave;

  ucfrb_rxq_if rxq ();

  ucfrb_rx_fifo u_rx_fifo (
    .clk_in(CLOCK_IN),
    .rst_n_in(RSTN_IN),
    .q(rxq.queue)
  );

  assign acc_done = PSEL_IN && PENABLE_IN && PREADY_OUT;
  assign wr_en = acc_done && PWRITE_IN;
  assign rd_en = acc_done && !PWRITE_IN;
  assign nbits = char_bits({char_size_top_bit, char_size_low});
  assign par_en = parity_mode_field[1];
  assign sync_master = sync_mode_select && clock_pin_direction;
  assign sync_slave = sync_mode_select && !clock_pin_direction;
  // Double speed is ignored outside async
  assign div_m1 = double_speed_bit ? ucfrb_pkg::DBL_DIV_M1 : ucfrb_pkg::NORM_DIV_M1;
  assign half_m1 = double_speed_bit ? ucfrb_pkg::DBL_HALF_M1 : ucfrb_pkg::NORM_HALF_M1;

  always_comb begin
    next_rdata = 32'h0;
    case (PADDR_IN)
      ucfrb_pkg::ADDR_DATA: next_rdata[7:0] = rxq.head.data[7:0];
      ucfrb_pkg::ADDR_STAT: begin
        next_rdata[ucfrb_pkg::ST_RXC] = rxq.count != 2'h0;
        next_rdata[ucfrb_pkg::ST_TXC] = transmit_complete_flag;
        next_rdata[ucfrb_pkg::ST_UDRE] = !tx_full;
        next_rdata[ucfrb_pkg::ST_FE] = rxq.head.fe;
        next_rdata[ucfrb_pkg::ST_DOR] = rxq.head.overrun_flag;
        next_rdata[ucfrb_pkg::ST_PERR] = rxq.head.perr;
        next_rdata[ucfrb_pkg::ST_U2X] = double_speed_bit;
      end
      ucfrb_pkg::ADDR_CTRLB: begin
        next_rdata[ucfrb_pkg::CB_RXEN] = rxen;
        next_rdata[ucfrb_pkg::CB_TXEN] = txen;
        next_rdata[ucfrb_pkg::CB_CSZ2] = char_size_top_bit;
        next_rdata[ucfrb_pkg::CB_RX_NINTH_BIT] = rxq.head.data[8];
        next_rdata[ucfrb_pkg::CB_TX_NINTH_BIT] = tx_ninth_bit;
      end
      ucfrb_pkg::ADDR_CTRLC: begin
        next_rdata[ucfrb_pkg::CC_SYNC] = sync_mode_select;
        next_rdata[ucfrb_pkg::CC_PARH:ucfrb_pkg::CC_PARL] = parity_mode_field;
        next_rdata[ucfrb_pkg::CC_STOP] = stop_bits_select;
        next_rdata[ucfrb_pkg::CC_CSZH:ucfrb_pkg::CC_CSZL] = char_size_low;
        next_rdata[ucfrb_pkg::CC_POL] = sync_clock_polarity;
      end
      ucfrb_pkg::ADDR_BAUDL: next_rdata[7:0] = baud_divisor[7:0];
      ucfrb_pkg::ADDR_BAUDH: next_rdata[3:0] = baud_divisor[11:8];
      ucfrb_pkg::ADDR_CLKDIR: next_rdata[ucfrb_pkg::CD_DIR] = clock_pin_direction;
      default: next_rdata = 32'h0;
    endcase
  end

  // One wait state: data is captured before the read pops the queue
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      PREADY_OUT <= 1'b0;
      PRDATA_OUT <= 32'h0;
      PSLVERR_OUT <= 1'b0;
    end else begin
      PREADY_OUT <= PSEL_IN && PENABLE_IN && !PREADY_OUT;
      if (PSEL_IN && PENABLE_IN && !PREADY_OUT) begin
        PRDATA_OUT <= PWRITE_IN ? 32'h0 : next_rdata;
        PSLVERR_OUT <= !mapped(PADDR_IN);
      end
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      double_speed_bit <= 1'b0;
      rxen <= 1'b0;
      txen <= 1'b0;
      char_size_top_bit <= 1'b0;
      tx_ninth_bit <= 1'b0;
      sync_mode_select <= 1'b0;
      parity_mode_field <= 2'h0;
      stop_bits_select <= 1'b0;
      char_size_low <= ucfrb_pkg::RST_CSZ;
      sync_clock_polarity <= 1'b0;
      clock_pin_direction <= 1'b0;
      baud_divisor <= ucfrb_pkg::RST_DIVISOR;
    end else if (wr_en) begin
      case (PADDR_IN)
        ucfrb_pkg::ADDR_STAT: double_speed_bit <= PWDATA_IN[ucfrb_pkg::ST_U2X];
        ucfrb_pkg::ADDR_CTRLB: begin
          rxen <= PWDATA_IN[ucfrb_pkg::CB_RXEN];
          txen <= PWDATA_IN[ucfrb_pkg::CB_TXEN];
          char_size_top_bit <= PWDATA_IN[ucfrb_pkg::CB_CSZ2];
          tx_ninth_bit <= PWDATA_IN[ucfrb_pkg::CB_TX_NINTH_BIT];
        end
        ucfrb_pkg::ADDR_CTRLC: begin
          // One format for both directions; a change mid-frame corrupts it
          sync_mode_select <= PWDATA_IN[ucfrb_pkg::CC_SYNC];
          parity_mode_field <= PWDATA_IN[ucfrb_pkg::CC_PARH:ucfrb_pkg::CC_PARL];
          stop_bits_select <= PWDATA_IN[ucfrb_pkg::CC_STOP];
          char_size_low <= PWDATA_IN[ucfrb_pkg::CC_CSZH:ucfrb_pkg::CC_CSZL];
          sync_clock_polarity <= PWDATA_IN[ucfrb_pkg::CC_POL];
        end
        ucfrb_pkg::ADDR_BAUDL: baud_divisor[7:0] <= PWDATA_IN[7:0];
        ucfrb_pkg::ADDR_BAUDH: baud_divisor[11:8] <= PWDATA_IN[3:0];
        ucfrb_pkg::ADDR_CLKDIR: clock_pin_direction <= PWDATA_IN[ucfrb_pkg::CD_DIR];
        default: ;
      endcase
    end
  end

  // Baud generator, free running in every mode
  logic [11:0] baud_cnt;
  logic baud_tick;
  logic bl_wr;
  assign baud_tick = baud_cnt == 12'h0;
  assign bl_wr = wr_en && PADDR_IN == ucfrb_pkg::ADDR_BAUDL;

  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      baud_cnt <= ucfrb_pkg::RST_DIVISOR;
    end else if (bl_wr) begin
      baud_cnt <= {baud_divisor[11:8], PWDATA_IN[7:0]};
    end else if (baud_tick) begin
      baud_cnt <= baud_divisor;
    end else begin
      baud_cnt <= baud_cnt - 12'h1;
    end
  end

  // Serial clock pin: master toggles per tick, slave is synchronised
  logic xck_s1;
  logic xck_s2;
  logic xck_s3;
  logic ck_rise;
  logic ck_fall;
  logic change_edge;
  logic sample_edge;

  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      XCK_OUT <= 1'b0;
      XCK_OE_OUT <= 1'b0;
    end else begin
      XCK_OE_OUT <= sync_master;
      if (!sync_master) begin
        XCK_OUT <= 1'b0;
      end else if (baud_tick) begin
        XCK_OUT <= !XCK_OUT;
      end
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      xck_s1 <= 1'b0;
      xck_s2 <= 1'b0;
      xck_s3 <= 1'b0;
    end else begin
      xck_s1 <= XCK_IN;
      xck_s2 <= xck_s1;
      xck_s3 <= xck_s2;
    end
  end

  assign ck_rise = sync_master ? (baud_tick && !XCK_OUT) : (sync_slave && xck_s2 && !xck_s3);
  assign ck_fall = sync_master ? (baud_tick && XCK_OUT) : (sync_slave && !xck_s2 && xck_s3);
  assign change_edge = sync_clock_polarity ? ck_fall : ck_rise;
  assign sample_edge = sync_clock_polarity ? ck_rise : ck_fall;

  // Transmitter
  logic [3:0] tx_phase;
  logic tx_step;
  logic [12:0] tx_sh;
  logic [3:0] tx_left;
  logic tx_busy;
  logic tx_load;
  logic tx_end;
  logic [12:0] tx_frame;
  assign tx_step = sync_mode_select ? change_edge : (baud_tick && tx_phase >= div_m1);
  assign tx_load = tx_step && tx_left == 4'h0 && tx_full && txen;
  assign tx_end = tx_step && tx_left == 4'h0 && tx_busy && !tx_load;
  assign tx_frame = make_frame(tx_buf, nbits, par_en, parity_of(tx_buf, nbits, parity_mode_field[0]));

  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      tx_phase <= 4'h0;
    end else if (baud_tick) begin
      tx_phase <= (tx_phase >= div_m1) ? 4'h0 : tx_phase + 4'h1;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      TXD_OUT <= 1'b1;
      tx_sh <= 13'h1fff;
      tx_left <= 4'h0;
      tx_busy <= 1'b0;
    end else if (tx_step) begin
      if (tx_left != 4'h0) begin
        TXD_OUT <= tx_sh[0];
        tx_sh <= {1'b1, tx_sh[12:1]};
        tx_left <= tx_left - 4'h1;
      end else if (tx_load) begin
        // Start bit goes out at once, so frames run back to back
        TXD_OUT <= 1'b0;
        tx_sh <= {1'b1, tx_frame[12:1]};
        tx_left <= 4'h1 + nbits + {3'h0, par_en} + {3'h0, stop_bits_select};
        tx_busy <= 1'b1;
      end else begin
        TXD_OUT <= 1'b1;
        tx_busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      tx_buf <= 9'h0;
      tx_full <= 1'b0;
      transmit_complete_flag <= 1'b0;
    end else begin
      if (wr_en && PADDR_IN == ucfrb_pkg::ADDR_DATA) begin
        tx_buf <= {tx_ninth_bit, PWDATA_IN[7:0]};
        tx_full <= 1'b1;
      end else if (tx_load) begin
        tx_full <= 1'b0;
      end
      // Hardware set wins over a write-one clear
      if (tx_end) begin
        transmit_complete_flag <= 1'b1;
      end else if (wr_en && PADDR_IN == ucfrb_pkg::ADDR_STAT && PWDATA_IN[ucfrb_pkg::ST_TXC]) begin
        transmit_complete_flag <= 1'b0;
      end
    end
  end

  // Receiver
  ucfrb_pkg::ucfrb_rx_state_t rx_state;
  logic [3:0] rx_phase;
  logic [3:0] rx_pos;
  logic [8:0] rx_data;
  logic rx_perr;
  logic rx_sample;
  logic start_det;
  logic rx_done;
  logic room;
  logic rx_hold;
  logic dor_pend;
  ucfrb_pkg::ucfrb_rx_entry_t rx_held;
  ucfrb_pkg::ucfrb_rx_entry_t new_entry;

  assign rx_sample = sync_mode_select ? sample_edge : (baud_tick && rx_phase >= div_m1);
  assign start_det = rx_state == ucfrb_pkg::RX_IDLE && rxen && !RXD_IN &&
                     (sync_mode_select ? sample_edge : baud_tick);
  assign rx_done = rx_state == ucfrb_pkg::RX_BITS && rx_sample && rx_pos == nbits + {3'h0, par_en};
  assign room = rxq.count != ucfrb_pkg::RXQ_FULL;
  assign new_entry = '{perr: rx_perr, overrun_flag: dor_pend, fe: !RXD_IN, data: rx_data};

  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rx_state <= ucfrb_pkg::RX_IDLE;
      rx_phase <= 4'h0;
      rx_pos <= 4'h0;
      rx_data <= 9'h0;
      rx_perr <= 1'b0;
    end else begin
      case (rx_state)
        ucfrb_pkg::RX_IDLE: begin
          if (start_det) begin
            rx_phase <= 4'h0;
            rx_pos <= 4'h0;
            rx_data <= 9'h0;
            rx_perr <= 1'b0;
            // Sync mode samples the start bit on its own edge
            rx_state <= sync_mode_select ? ucfrb_pkg::RX_BITS : ucfrb_pkg::RX_START;
          end
        end
        ucfrb_pkg::RX_START: begin
          if (baud_tick) begin
            rx_phase <= rx_phase + 4'h1;
            if (rx_phase >= half_m1) begin
              // High at mid start bit is a glitch, not a frame
              rx_state <= RXD_IN ? ucfrb_pkg::RX_IDLE : ucfrb_pkg::RX_BITS;
              rx_phase <= 4'h0;
            end
          end
        end
        ucfrb_pkg::RX_BITS: begin
          if (baud_tick && !sync_mode_select) begin
            rx_phase <= (rx_phase >= div_m1) ? 4'h0 : rx_phase + 4'h1;
          end
          if (rx_sample) begin
            rx_pos <= rx_pos + 4'h1;
            if (rx_pos < nbits) begin
              rx_data[rx_pos] <= RXD_IN;
            end else if (par_en && rx_pos == nbits) begin
              rx_perr <= RXD_IN != parity_of(rx_data, nbits, parity_mode_field[0]);
            end else begin
              rx_state <= ucfrb_pkg::RX_IDLE;
            end
          end
        end
        default: rx_state <= ucfrb_pkg::RX_IDLE;
      endcase
    end
  end

  // Third level: a finished character waits here while the queue is full
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rx_hold <= 1'b0;
      rx_held <= '0;
      dor_pend <= 1'b0;
    end else begin
      if (rx_hold && room) begin
        rx_hold <= 1'b0;
      end else if (rx_hold && start_det) begin
        rx_hold <= 1'b0;
        dor_pend <= 1'b1;
      end else if (rx_done && !room) begin
        rx_hold <= 1'b1;
        rx_held <= new_entry;
        dor_pend <= 1'b0;
      end
      if (rx_done && room) begin
        dor_pend <= 1'b0;
      end
    end
  end

  assign rxq.push = room && (rx_hold || rx_done);
  assign rxq.push_entry = rx_hold ? rx_held : new_entry;
  assign rxq.pop = rd_en && PADDR_IN == ucfrb_pkg::ADDR_DATA;

  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RSTN_IN);

  a_baud_reload_zero: assert property (baud_tick && !bl_wr |=> baud_cnt == $past(baud_divisor))
    else $error("baud counter did not reload divisor at zero");
  a_baud_low_write: assert property (bl_wr |=> baud_cnt == baud_divisor)
    else $error("low divisor write did not reload counter");
  a_xck_async_idle: assert property (!sync_mode_select [*2] |-> !XCK_OE_OUT && !XCK_OUT)
    else $error("clock pin active outside sync mode");
  a_master_clock_div: assert property (sync_master && baud_tick |=> XCK_OUT != $past(XCK_OUT))
    else $error("master clock did not toggle on baud tick");
  a_slave_edge_delay: assert property ($rose(XCK_IN) ##1 XCK_IN |-> ##1 (xck_s2 && !xck_s3))
    else $error("slave clock edge not seen two clocks later");
  a_async_bit_spacing: assert property (!sync_mode_select && tx_step |=> (!tx_step || sync_mode_select) [*7])
    else $error("async bit shorter than eight ticks");
  a_tx_start_low: assert property (tx_load |=> !TXD_OUT && tx_busy)
    else $error("frame did not begin with a low start bit");
  a_tx_idle_high: assert property (tx_end |=> TXD_OUT && !tx_busy && transmit_complete_flag)
    else $error("line not high after last stop bit");
  a_rx_hold_third: assert property (rx_done && !room && !rx_hold |=> rx_hold && rx_held.data == $past(rx_data))
    else $error("full queue did not keep character in shifter");
  a_frame_error_stop: assert property (rx_done && rxq.count == 2'h0 |=> rxq.head.fe == !$past(RXD_IN))
    else $error("frame error not tied to first stop bit");

  c_master_frame: cover property (sync_master && tx_load);
  c_held_char: cover property (rx_hold && room);
  c_back_to_back: cover property (tx_load ##[1:300] tx_load);
  c_double_speed_rx: cover property (double_speed_bit && rx_done);
endmodule

// ### verif/ucfrb_far.sv
`timescale 1ns/1ps
module ucfrb_far (
  // Clock
  input wire logic clk_in,
  // Bit length in clocks
  input wire logic [7:0] bit_clks_in,
  // Serial lines
  input wire logic txd_in,
  output logic rxd_out,
  // Slave clock
  output logic xck_out
);
  initial rxd_out = 1'b1;
  initial xck_out = 1'b0;
  // Slave clock at an eighth of the system clock, well inside the limit
  task automatic sync_recv(input int n, output logic [15:0] v);
    v = 16'h0000;
    for (int i = 0; i < n; i++) begin
      xck_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      v[i] = txd_in;
      xck_out <= 1'b0;
      repeat (4) @(posedge clk_in);
    end
  endtask
  // Trailing high bit leaves the line idle between calls
  task automatic send(input logic [7:0] d, input logic stp);
    logic [10:0] f;
    f = {1'b1, stp, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd_out <= f[i];
      repeat (bit_clks_in) @(posedge clk_in);
    end
  endtask
  // Sample mid-bit, so small phase slips do not matter
  task automatic recv(input int n, output logic [15:0] v);
    v = 16'h0000;
    @(negedge txd_in);
    repeat (bit_clks_in / 2) @(posedge clk_in);
    for (int i = 0; i < n; i++) begin
      repeat (bit_clks_in) @(posedge clk_in);
      v[i] = txd_in;
    end
  endtask
endmodule

// ### verif/test_ucfrb_top.sv
`timescale 1ns/1ps
module test_ucfrb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h00000000;
  logic [31:0] prd;
  logic [31:0] r;
  logic pready, perr, e, txd, rxd, serial_clock_pin, xck_oe, ext_clk;
  logic [15:0] v;
  int error_cnt = 0;
  int checks_done = 0;
  always #10 clk = ~clk;
  ucfrb_top dut(.CLOCK_IN(clk), .RSTN_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(pa), .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(pready), .PSLVERR_OUT(perr),
    .RXD_IN(rxd), .TXD_OUT(txd), .XCK_IN(ext_clk), .XCK_OUT(serial_clock_pin), .XCK_OE_OUT(xck_oe));
  // Divisor 1: tick every 2 clocks, 16 ticks a bit
  ucfrb_far far(.clk_in(clk), .bit_clks_in(8'd32), .txd_in(txd), .rxd_out(rxd), .xck_out(ext_clk));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic end_of_test;
    $display("Checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, ucfrb_pkg::ADDR_CTRLC, 32'h0);
    chk("ctrlc reset", 32'h00000006, r);
    apb(1'b0, 8'h1c, 32'h0);
    chk("slverr", 32'h1, {31'h0, e});
    apb(1'b1, ucfrb_pkg::ADDR_BAUDL, 32'h1);
    apb(1'b1, ucfrb_pkg::ADDR_CTRLB, 32'h18);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, ucfrb_pkg::ADDR_STAT, 32'h40);
      apb(1'b1, ucfrb_pkg::ADDR_CTRLC, 32'h26 | (i << 4));
      apb(1'b1, ucfrb_pkg::ADDR_DATA, 32'ha7);
      far.recv(10, v);
      chk("tx frame", 32'h3a7 ^ (i << 8), {16'h0, v});
    end
    repeat (24) @(posedge clk);
    apb(1'b0, ucfrb_pkg::ADDR_STAT, 32'h0);
    chk("tx done", 32'h1, {31'h0, r[6]});
    apb(1'b1, ucfrb_pkg::ADDR_CTRLC, 32'h06);
    far.send(8'h11, 1'b1);
    far.send(8'h22, 1'b1);
    far.send(8'h33, 1'b1);
    for (int i = 1; i < 4; i++) begin
      apb(1'b0, ucfrb_pkg::ADDR_STAT, 32'h0);
      chk("rx ready", 32'h1, {31'h0, r[7]});
      apb(1'b0, ucfrb_pkg::ADDR_DATA, 32'h0);
      chk("rx data", 32'h11 * i, {24'h0, r[7:0]});
    end
    far.send(8'h5a, 1'b0);
    apb(1'b0, ucfrb_pkg::ADDR_STAT, 32'h0);
    chk("frame err", 32'h1, {31'h0, r[4]});
    apb(1'b0, ucfrb_pkg::ADDR_DATA, 32'h0);
    chk("rx data", 32'h5a, {24'h0, r[7:0]});
    apb(1'b0, ucfrb_pkg::ADDR_STAT, 32'h0);
    chk("rx empty", 32'h0, {31'h0, r[7]});
    apb(1'b1, ucfrb_pkg::ADDR_CTRLC, 32'h46);
    apb(1'b1, ucfrb_pkg::ADDR_DATA, 32'ha7);
    far.sync_recv(10, v);
    chk("slave frame", 32'h34e, {16'h0, v});
    apb(1'b1, ucfrb_pkg::ADDR_CLKDIR, 32'h1);
    apb(1'b1, ucfrb_pkg::ADDR_CTRLC, 32'h46);
    repeat (2) @(posedge clk);
    chk("clk oe", 32'h1, {31'h0, xck_oe});
    r[0] = serial_clock_pin;
    repeat (2) @(posedge clk);
    chk("clk out", {31'h0, ~r[0]}, {31'h0, serial_clock_pin});
    apb(1'b1, ucfrb_pkg::ADDR_CTRLC, 32'h06);
    repeat (2) @(posedge clk);
    chk("clk oe", 32'h0, {31'h0, xck_oe});
    end_of_test();
  end
endmodule
